// ==== core/sse_pkg.sv ====
// Constants shared by the synchronous serial engine port: modes, opcodes and timing.
// Assumes a single 50 MHz core clock and a byte-wide command pipe from the USB core.
package sse_pkg;

	// Mode-select values and the channel that hosts the engine.
	localparam logic [7:0] SSE_MODE_RESET   = 8'h00;
	localparam logic [7:0] SSE_MODE_ENGINE  = 8'h02;
	localparam logic [0:0] SSE_ENGINE_CHAN  = 1'h0;

	// Command opcodes taken from the data pipe.
	localparam logic [7:0] SSE_OP_SHIFT     = 8'h10;
	localparam logic [7:0] SSE_OP_SET_LOW   = 8'h80;
	localparam logic [7:0] SSE_OP_READ_LOW  = 8'h81;
	localparam logic [7:0] SSE_OP_SET_HIGH  = 8'h82;
	localparam logic [7:0] SSE_OP_READ_HIGH = 8'h83;
	localparam logic [7:0] SSE_OP_SET_DIV   = 8'h86;
	localparam logic [7:0] SSE_OP_SET_CFG   = 8'h8a;
	localparam logic [7:0] SSE_OP_SET_SEL   = 8'h90;

	// Field positions inside the configuration byte.
	localparam int SSE_CFG_CPOL_BIT = 0;
	localparam int SSE_CFG_LSB_BIT  = 1;

	// Reset values of the engine state.
	localparam logic [7:0] SSE_DIV_RESET = 8'h00;
	localparam logic       SSE_SEL_RESET = 1'b1;

	// Rate ceiling and the derived least half period of the serial clock.
	localparam int CLK_KHZ       = 50000;
	localparam int MAX_RATE_KBPS = 5600;
	localparam int MIN_HALF_INT  = (CLK_KHZ + 2 * MAX_RATE_KBPS - 1) / (2 * MAX_RATE_KBPS);
	localparam logic [8:0] MIN_HALF = MIN_HALF_INT[8:0];

	// Engine sequencer states.
	typedef enum logic [2:0] {
		SSE_IDLE,
		SSE_ARG1,
		SSE_ARG2,
		SSE_SHIFT_LO,
		SSE_SHIFT_HI,
		SSE_PUSH
	} sse_state_t;

endpackage

// ==== core/sse_port.sv ====
// Synchronous serial engine: decodes pipe commands, drives serial and general lines.
// Assumes pins are resolved outside from value and enable; answers drain via resp_ready.
`timescale 1ns/1ns

module sse_port
	import sse_pkg::*;
(
	// Clock and synchronous active-low reset.
	input  wire logic       mclk,
	input  wire logic       resetn,
	// Mode-select command from the USB core.
	input  wire logic       mode_valid,
	input  wire logic [7:0] mode_value,
	input  wire logic       mode_channel,
	// Command byte pipe.
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_data,
	output logic            cmd_ready,
	// Answer byte pipe.
	output logic            resp_valid,
	output logic [7:0]      resp_data,
	input  wire logic       resp_ready,
	// Serial lines.
	output logic            serial_clock_out,
	output logic            serial_clock_oe,
	output logic            serial_data_out,
	output logic            serial_data_oe,
	input  wire logic       serial_data_in,
	output logic            select_out,
	output logic            select_oe,
	// General lines, low and high groups.
	input  wire logic [3:0] gp_low_line_in,
	output logic [3:0]      gp_low_line_out,
	output logic [3:0]      gp_low_line_oe,
	input  wire logic [3:0] gp_high_line_in,
	output logic [3:0]      gp_high_line_out,
	output logic [3:0]      gp_high_line_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin input synchronisers.

	logic [8:0] sync_a;   // First stage, read only by the second.
	logic [8:0] sync_b;   // Second stage, safe to use.

	// Two flops on every pin input before any logic looks at it.
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sync_a <= 9'h000;
			sync_b <= 9'h000;
		end
		else
		begin
			sync_a <= {serial_data_in, gp_high_line_in, gp_low_line_in};
			sync_b <= sync_a;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Engine sequencer.

	sse_state_t state, next_state;             // Sequencer state.
	logic       engine_on, next_engine_on;     // Engine mode selected.
	logic [7:0] cmd, next_cmd;                 // Opcode in progress.
	logic [7:0] arg1, next_arg1;               // First argument byte.
	logic [7:0] shreg, next_shreg;             // Shift register.
	logic [2:0] bitcnt, next_bitcnt;           // Bits left minus one.
	logic [8:0] timer, next_timer;             // Half-period countdown.
	logic [7:0] div, next_div;                 // Extra half-period cycles.
	logic       cpol, next_cpol;               // Idle clock level.
	logic       lsbf, next_lsbf;               // Shift least significant first.
	logic       sel, next_sel;                 // Select line level.
	logic       sdo, next_sdo;                 // Serial data out level.
	logic [7:0] rdata, next_rdata;             // Byte waiting to be answered.
	logic [3:0] low_val, next_low_val;         // Low group values.
	logic [3:0] low_dir, next_low_dir;         // Low group directions, 1 drives.
	logic [3:0] high_val, next_high_val;       // High group values.
	logic [3:0] high_dir, next_high_dir;       // High group directions, 1 drives.
	logic       push;                          // Answer offered to the buffer.
	logic       buf_in_ready;                  // Buffer has room.

	// Pick the bit to drive next from the shift register.
	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction

	// Command bytes are only taken while the sequencer waits for them.
	assign cmd_ready = engine_on
	                 && (state == SSE_IDLE || state == SSE_ARG1 || state == SSE_ARG2);
	assign push = (state == SSE_PUSH);

	// Next-state logic for the whole sequencer.
	always_comb
	begin
		next_state    = state;
		next_engine_on = engine_on;
		next_cmd      = cmd;
		next_arg1     = arg1;
		next_shreg    = shreg;
		next_bitcnt   = bitcnt;
		next_timer    = timer;
		next_div      = div;
		next_cpol     = cpol;
		next_lsbf     = lsbf;
		next_sel      = sel;
		next_sdo      = sdo;
		next_rdata    = rdata;
		next_low_val  = low_val;
		next_low_dir  = low_dir;
		next_high_val = high_val;
		next_high_dir = high_dir;
		case (state)
			// Take an opcode; read commands answer at once.
			SSE_IDLE:
			begin
				if (cmd_valid && cmd_ready)
				begin
					next_cmd = cmd_data;
					if (cmd_data == SSE_OP_READ_LOW)
					begin
						next_rdata = {4'h0, sync_b[3:0]};
						next_state = SSE_PUSH;
					end
					else if (cmd_data == SSE_OP_READ_HIGH)
					begin
						next_rdata = {4'h0, sync_b[7:4]};
						next_state = SSE_PUSH;
					end
					else if (cmd_data == SSE_OP_SHIFT || cmd_data == SSE_OP_SET_LOW
					      || cmd_data == SSE_OP_SET_HIGH || cmd_data == SSE_OP_SET_DIV
					      || cmd_data == SSE_OP_SET_CFG || cmd_data == SSE_OP_SET_SEL)
					begin
						next_state = SSE_ARG1;
					end
				end
			end
			// First argument; divider, config and select commands complete here, a shift starts.
			SSE_ARG1:
			begin
				if (cmd_valid && cmd_ready)
				begin
					next_arg1 = cmd_data;
					next_state = SSE_IDLE;
					if (cmd == SSE_OP_SHIFT)
					begin
						next_shreg  = cmd_data;
						next_sdo    = out_bit(cmd_data, lsbf);
						next_bitcnt = 3'h7;
						next_timer  = MIN_HALF + {1'b0, div};
						next_state  = SSE_SHIFT_LO;
					end
					else if (cmd == SSE_OP_SET_DIV)
						next_div = cmd_data;
					else if (cmd == SSE_OP_SET_CFG)
					begin
						next_cpol = cmd_data[SSE_CFG_CPOL_BIT];
						next_lsbf = cmd_data[SSE_CFG_LSB_BIT];
					end
					else if (cmd == SSE_OP_SET_SEL)
						next_sel = cmd_data[0];
					else
						next_state = SSE_ARG2;
				end
			end
			// Second argument: direction byte of a group write.
			SSE_ARG2:
			begin
				if (cmd_valid && cmd_ready)
				begin
					next_state = SSE_IDLE;
					if (cmd == SSE_OP_SET_LOW)
					begin
						next_low_val = arg1[3:0];
						next_low_dir = cmd_data[3:0];
					end
					else
					begin
						next_high_val = arg1[3:0];
						next_high_dir = cmd_data[3:0];
					end
				end
			end
			// Idle-level half; sample at its end as the clock leaves idle.
			SSE_SHIFT_LO:
			begin
				if (timer == 9'h001)
				begin
					next_timer = MIN_HALF + {1'b0, div};
					next_shreg = lsbf ? {sync_b[8], shreg[7:1]}
					                  : {shreg[6:0], sync_b[8]};
					next_state = SSE_SHIFT_HI;
				end
				else
					next_timer = timer - 9'h001;
			end
			// Active half; the clock returns to idle and the next bit goes out.
			SSE_SHIFT_HI:
			begin
				if (timer == 9'h001)
				begin
					next_timer = MIN_HALF + {1'b0, div};
					if (bitcnt == 3'h0)
					begin
						next_rdata = shreg;
						next_state = SSE_PUSH;
					end
					else
					begin
						next_bitcnt = bitcnt - 3'h1;
						next_sdo    = out_bit(shreg, lsbf);
						next_state  = SSE_SHIFT_LO;
					end
				end
				else
					next_timer = timer - 9'h001;
			end
			// Hold the answer until the buffer takes it, then take the next command.
			SSE_PUSH:
			begin
				if (buf_in_ready)
					next_state = SSE_IDLE;
			end
			default:
				next_state = SSE_IDLE;
		endcase
		// Mode select: only the first channel can host the engine.
		if (mode_valid && mode_channel == SSE_ENGINE_CHAN)
		begin
			next_engine_on = (mode_value == SSE_MODE_ENGINE);
			if (mode_value == SSE_MODE_RESET)
			begin
				next_state    = SSE_IDLE;
				next_div      = SSE_DIV_RESET;
				next_cpol     = 1'b0;
				next_lsbf     = 1'b0;
				next_sel      = SSE_SEL_RESET;
				next_sdo      = 1'b0;
				next_low_val  = 4'h0;
				next_low_dir  = 4'h0;
				next_high_val = 4'h0;
				next_high_dir = 4'h0;
			end
		end
	end

	// Register the sequencer.
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state     <= SSE_IDLE;
			engine_on <= 1'b0;
			cmd       <= 8'h00;
			arg1      <= 8'h00;
			shreg     <= 8'h00;
			bitcnt    <= 3'h0;
			timer     <= 9'h000;
			div       <= SSE_DIV_RESET;
			cpol      <= 1'b0;
			lsbf      <= 1'b0;
			sel       <= SSE_SEL_RESET;
			sdo       <= 1'b0;
			rdata     <= 8'h00;
			low_val   <= 4'h0;
			low_dir   <= 4'h0;
			high_val  <= 4'h0;
			high_dir  <= 4'h0;
		end
		else
		begin
			state     <= next_state;
			engine_on <= next_engine_on;
			cmd       <= next_cmd;
			arg1      <= next_arg1;
			shreg     <= next_shreg;
			bitcnt    <= next_bitcnt;
			timer     <= next_timer;
			div       <= next_div;
			cpol      <= next_cpol;
			lsbf      <= next_lsbf;
			sel       <= next_sel;
			sdo       <= next_sdo;
			rdata     <= next_rdata;
			low_val   <= next_low_val;
			low_dir   <= next_low_dir;
			high_val  <= next_high_val;
			high_dir  <= next_high_dir;
		end
	end

	// Pins follow the engine only in engine mode; otherwise they are released.
	assign serial_clock_out = (state == SSE_SHIFT_HI) ^ cpol;
	assign serial_clock_oe  = engine_on;
	assign serial_data_out  = sdo;
	assign serial_data_oe   = engine_on;
	assign select_out       = sel;
	assign select_oe        = engine_on;
	assign gp_low_line_out  = low_val;
	assign gp_low_line_oe   = engine_on ? low_dir : 4'h0;
	assign gp_high_line_out = high_val;
	assign gp_high_line_oe  = engine_on ? high_dir : 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry answer buffer; a stalled reader stalls the sequencer in PUSH.

	logic [7:0] buf_mem [2];               // Storage.
	logic [7:0] next_mem0, next_mem1;      // Next storage contents.
	logic       wptr, next_wptr;           // Write slot.
	logic       rptr, next_rptr;           // Read slot.
	logic [1:0] count, next_count;         // Entries held.

	assign buf_in_ready = (count != 2'h2);
	assign resp_valid   = (count != 2'h0);
	assign resp_data    = buf_mem[rptr];

	// Next buffer state from push and pop.
	always_comb
	begin
		next_mem0  = buf_mem[0];
		next_mem1  = buf_mem[1];
		next_wptr  = wptr;
		next_rptr  = rptr;
		next_count = count;
		if (push && buf_in_ready)
		begin
			if (wptr)
				next_mem1 = rdata;
			else
				next_mem0 = rdata;
			next_wptr = ~wptr;
		end
		if (resp_valid && resp_ready)
			next_rptr = ~rptr;
		next_count = count + {1'b0, push && buf_in_ready} - {1'b0, resp_valid && resp_ready};
	end

	// Register the buffer.
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			buf_mem[0] <= 8'h00;
			buf_mem[1] <= 8'h00;
			wptr       <= 1'b0;
			rptr       <= 1'b0;
			count      <= 2'h0;
		end
		else
		begin
			buf_mem[0] <= next_mem0;
			buf_mem[1] <= next_mem1;
			wptr       <= next_wptr;
			rptr       <= next_rptr;
			count      <= next_count;
		end
	end

endmodule

// ==== bench/sse_peer_model.sv ====
// Serial target model facing the engine's clock, data and select.
// Assumes the bench sets polarity, bit order and reply before select falls.
`timescale 1ns/1ns
module sse_peer_model (
	// Engine lines.
	input  wire logic       sclk,
	input  wire logic       sel,
	input  wire logic       mosi,
	output logic            miso,
	// Bench set-up and the byte seen.
	input  wire logic       cpol,
	input  wire logic       lsb,
	input  wire logic [7:0] tx,
	output logic [7:0]      rx
);
	logic [7:0] sh; // Reply bits left.
	// A released line sits at its pull-up level.
	assign miso = sel ? 1'b1 : (lsb ? sh[0] : sh[7]);
	// Load the reply as select falls.
	always @(negedge sel)
		sh = tx;
	// Capture on the leading edge, advance on the trailing one.
	always @(sclk)
		if (!sel && sclk !== cpol)
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		else if (!sel)
			sh = lsb ? sh >> 1 : sh << 1;
endmodule

// ==== bench/sse_port_monitor.sv ====
// Checker on the engine port's pins and pipes.
// Assumes it is bound into sse_port; one clock domain.
`timescale 1ns/1ns
module sse_port_monitor
	import sse_pkg::*;
(
	// Clock, reset and mode command.
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       mode_valid,
	input wire logic [7:0] mode_value,
	input wire logic       mode_channel,
	// Pipes and pin drivers.
	input wire logic       cmd_ready,
	input wire logic       resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic       resp_ready,
	input wire logic       serial_clock_out,
	input wire logic       serial_clock_oe,
	input wire logic       serial_data_oe,
	input wire logic       select_out,
	input wire logic [3:0] gp_low_line_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	////////////////////
	chk_engine_on:
		assert property (mode_valid && mode_value == SSE_MODE_ENGINE && !mode_channel
			|=> cmd_ready && serial_clock_oe) else $error("engine not on");
	chk_soft_reset:
		assert property (mode_valid && mode_value == SSE_MODE_RESET && !mode_channel
			|=> !cmd_ready && select_out && !serial_clock_oe) else $error("no reset");
	chk_second_chan:
		assert property (mode_valid && mode_channel |=> $stable(serial_clock_oe))
			else $error("second channel acted");
	chk_ready_gate:
		assert property (cmd_ready |-> serial_clock_oe) else $error("ready while off");
	chk_pin_set:
		assert property (serial_clock_oe == serial_data_oe) else $error("oe split");
	chk_gp_off:
		assert property (!serial_clock_oe |-> gp_low_line_oe == 4'h0) else $error("gp oe");
	chk_rate_cap:
		assert property ($changed(serial_clock_out) |=> $stable(serial_clock_out)[*4])
			else $error("clock too fast");
	chk_resp_hold:
		assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
			else $error("answer dropped");
endmodule
bind sse_port sse_port_monitor sse_port_monitor_i (.mclk(mclk), .resetn(resetn),
	.mode_valid(mode_valid), .mode_value(mode_value), .mode_channel(mode_channel),
	.cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
	.resp_ready(resp_ready), .serial_clock_out(serial_clock_out),
	.serial_clock_oe(serial_clock_oe), .serial_data_oe(serial_data_oe),
	.select_out(select_out), .gp_low_line_oe(gp_low_line_oe));

// ==== bench/tb_sse_port.sv ====
// Self-checking bench for the engine port with a serial target model.
// Assumes 50 MHz mclk; pins resolve from the enables below.
`timescale 1ns/1ns
module tb_sse_port;
	import sse_pkg::*;
	logic       mclk = 1'b0;
	logic       resetn, mode_valid, mode_channel, cmd_valid, cmd_ready;
	logic       resp_valid, resp_ready, sck, sck_oe, sdo, sdo_oe, sdi, sel, sel_oe;
	logic       cpol, lsb;
	logic [7:0] mode_value, cmd_data, resp_data, tx, rx, d;
	logic [3:0] gl_in, gl_out, gl_oe, gh_in, gh_out, gh_oe, ext, v, dr;
	logic [3:0] g [2], gv [2], gd [2];
	int         err_count, checks_done;
	// Each general line reads its own drive, else the outside level, inverted for the high group.
	assign gl_in = (gl_oe & gl_out) | (~gl_oe & ext);
	assign gh_in = (gh_oe & gh_out) | (~gh_oe & ~ext);
	sse_port sse_port_i (.mclk(mclk), .resetn(resetn), .mode_valid(mode_valid),
		.mode_value(mode_value), .mode_channel(mode_channel), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_ready(resp_ready), .serial_clock_out(sck),
		.serial_clock_oe(sck_oe), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
		.serial_data_in(sdi), .select_out(sel), .select_oe(sel_oe),
		.gp_low_line_in(gl_in), .gp_low_line_out(gl_out), .gp_low_line_oe(gl_oe),
		.gp_high_line_in(gh_in), .gp_high_line_out(gh_out), .gp_high_line_oe(gh_oe));
	sse_peer_model sse_peer_model_i (.sclk(sck), .sel(sel), .mosi(sdo), .miso(sdi),
		.cpol(cpol), .lsb(lsb), .tx(tx), .rx(rx));
	always #10 mclk = ~mclk;
	////////////////////
	// Expected level of a general line group.
	function automatic logic [3:0] pin(input logic [3:0] val, dir, e);
		pin = (val & dir) | (e & ~dir);
	endfunction
	// Engine on, select and ready packed for one compare.
	function automatic logic [7:0] st();
		st = {3'h0, sdo_oe, sel_oe, sck_oe, sel, cmd_ready};
	endfunction
	task check(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %0t got %h want %h", $time, got, exp);
			err_count++;
		end
	endtask
	// Hold a byte until the edge that takes it; valid stays up for back-to-back use.
	task send(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge mclk);
		cmd_valid = 1;
		cmd_data = b;
		while (cmd_ready !== 1'b1 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			$display("wrong value %0t command byte never taken", $time);
			err_count++;
			test_done();
		end
		@(posedge mclk);
	endtask
	task idle();
		@(negedge mclk);
		cmd_valid = 0;
	endtask
	// Take one answer and compare it.
	task get(input logic [7:0] e);
		int n;
		n = 0;
		@(negedge mclk);
		while (resp_valid !== 1'b1 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			$display("wrong value %0t answer never offered", $time);
			err_count++;
			test_done();
		end
		check(resp_data, e);
		resp_ready = 1;
		@(negedge mclk);
		resp_ready = 0;
	endtask
	task mode(input logic [7:0] val, input logic ch);
		@(negedge mclk);
		mode_valid = 1;
		mode_value = val;
		mode_channel = ch;
		@(negedge mclk);
		mode_valid = 0;
		@(negedge mclk);
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////
	initial
	begin
		{resetn, mode_valid, mode_channel, cmd_valid, resp_ready} = 5'h0;
		{mode_value, cmd_data, tx, cpol, lsb, ext} = 30'h0;
		void'($urandom(74));
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		resetn = 1;
		check(st(), 8'h02);
		mode(SSE_MODE_ENGINE, 1'b1);
		check(st(), 8'h02);
		mode(SSE_MODE_ENGINE, 1'b0);
		check(st(), 8'h1f);
		$display("test mode done");
		// Every polarity and bit order, random divider and bytes.
		for (int c = 0; c < 4; c++)
		begin
			d = $urandom;
			tx = $urandom;
			{lsb, cpol} = 2'(c);
			send(SSE_OP_SET_CFG);
			send(8'(c));
			send(SSE_OP_SET_DIV);
			send(8'($urandom % 4));
			send(SSE_OP_SET_SEL);
			send(8'h00);
			send(SSE_OP_SHIFT);
			send(d);
			send(SSE_OP_SET_SEL);
			send(8'h01);
			idle();
			get(tx);
			check(rx, d);
			check({7'h0, sck}, {7'h0, cpol});
			check(st(), 8'h1f);
		end
		$display("test shift done");
		// Both general groups: set, let inputs settle, read back.
		for (int k = 0; k < 2; k++)
		begin
			v = $urandom;
			dr = $urandom;
			ext = $urandom;
			send(SSE_OP_SET_LOW + 8'(2 * k));
			send({4'h0, v});
			send({4'h0, dr});
			idle();
			repeat (4) @(negedge mclk);
			g[k] = pin(v, dr, k == 0 ? ext : ~ext);
			gv[k] = v;
			gd[k] = dr;
			send(SSE_OP_READ_LOW + 8'(2 * k));
			idle();
			get({4'h0, g[k]});
		end
		check({gl_oe, gh_oe}, {gd[0], gd[1]});
		// The outside level changed since the low group was read; expect the new one.
		g[0] = pin(gv[0], gd[0], ext);
		$display("test general lines done");
		// Fill the answer buffer, stall, then drain in order.
		send(8'h3c);
		send(SSE_OP_READ_LOW);
		send(SSE_OP_READ_HIGH);
		send(SSE_OP_READ_LOW);
		idle();
		repeat (8) @(negedge mclk);
		check({7'h0, cmd_ready}, 8'h00);
		get({4'h0, g[0]});
		get({4'h0, g[1]});
		get({4'h0, g[0]});
		$display("test buffer done");
		send(SSE_OP_SET_SEL);
		send(8'h00);
		idle();
		mode(SSE_MODE_RESET, 1'b0);
		check(st(), 8'h02);
		check({gl_oe, gh_oe}, 8'h00);
		$display("test soft reset done");
		test_done();
	end
	// Cut a hang short.
	initial
	begin
		#1000000;
		err_count++;
		test_done();
	end
endmodule
